// ==== sim/core_model.sv ====
// Behavioural CPU core model counting clock ticks and sequencer requests
`timescale 1ns/1ps
`default_nettype none
module core_model #(
   parameter logic [1:0] PRIO = 2'h1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cpu_tick_i,
   input  wire logic        per_tick_i,
   input  wire logic        mask_force_i,
   input  wire logic        service_i,
   input  wire logic        fetch_i,
   input  wire logic        wdg_rst_i,
   output logic [15:0]      cpu_ticks_o,
   output logic [15:0]      per_ticks_o,
   output logic [7:0]       services_o,
   output logic [7:0]       fetches_o,
   output logic [7:0]       wdg_rsts_o,
   output logic [1:0]       mask_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_ticks_o <= 16'h0;
         per_ticks_o <= 16'h0;
         services_o  <= 8'h0;
         fetches_o   <= 8'h0;
         wdg_rsts_o  <= 8'h0;
         mask_o      <= 2'h3;
      end else begin
         cpu_ticks_o <= cpu_ticks_o + 16'(cpu_tick_i);
         per_ticks_o <= per_ticks_o + 16'(per_tick_i);
         services_o  <= services_o + 8'(service_i);
         fetches_o   <= fetches_o + 8'(fetch_i);
         wdg_rsts_o  <= wdg_rsts_o + 8'(wdg_rst_i);
         if (service_i) begin
            mask_o <= PRIO;
         end else if (mask_force_i) begin
            mask_o <= 2'h2;
         end
      end
   end
endmodule : core_model
`default_nettype wire

// ==== sim/power_saving_mode_controller_tb.sv ====
// Self-checking bench of the power saving mode controller
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"
module power_saving_mode_controller_tb;
   localparam logic [5:0] ev_wait = 6'h01, ev_halt = 6'h02, ev_pend = 6'h04;
   localparam logic [5:0] ev_rtc = 6'h08, ev_hwake = 6'h10, ev_rst = 6'h20;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rd, dat_o, seed = 32'ha12d;
   logic [5:0]  ev = 6'h0;
   logic        wdg_on = 1'b0, wdg_opt = 1'b1, dly_opt = 1'b0;
   logic        ack_o, cpu_clk_en_o, periph_clk_en_o, osc_on_o, rtc_run_o;
   logic        mask_force_o, irq_service_o, reset_fetch_o, watchdog_reset_o;
   logic [2:0]  mode_o;
   logic [15:0] cpu_n, per_n, c0, p0;
   logic [7:0]  srv, rfe, wdr, s0, f0, w0;
   logic [1:0]  mask;
   int          num_errors = 0, compares = 0, d, k;

   power_mode_ctrl u_dut (
      .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o, .ack_o, .wait_instr_i(ev[0]),
      .halt_instr_i(ev[1]), .irq_pending_i(ev[2]), .rtc_irq_i(ev[3]),
      .halt_wake_irq_i(ev[4]), .reset_req_i(ev[5]),
      .watchdog_active_i(wdg_on), .watchdog_halt_option_i(wdg_opt),
      .delay_option_i(dly_opt), .cpu_clk_en_o, .periph_clk_en_o,
      .osc_on_o, .rtc_run_o, .mask_force_o, .irq_service_o,
      .reset_fetch_o, .watchdog_reset_o, .mode_o);

   core_model u_core (
      .clk_i, .rst_i, .cpu_tick_i(cpu_clk_en_o),
      .per_tick_i(periph_clk_en_o), .mask_force_i(mask_force_o),
      .service_i(irq_service_o), .fetch_i(reset_fetch_o),
      .wdg_rst_i(watchdog_reset_o), .cpu_ticks_o(cpu_n),
      .per_ticks_o(per_n), .services_o(srv), .fetches_o(rfe),
      .wdg_rsts_o(wdr), .mask_o(mask));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // Ticks in a span that is a multiple of the slow period
   function automatic int exp_ticks(input int span, input int s);
      return span >> (s + 1);
   endfunction : exp_ticks

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      sel <= 4'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      if (n >= 50) num_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic pulse(input logic [5:0] m);
      ev <= m;
      @(posedge clk_i);
      ev <= 6'h0;
      wt(2);
   endtask : pulse

   task automatic snap;
      c0 = cpu_n;
      p0 = per_n;
      s0 = srv;
      f0 = rfe;
      w0 = wdr;
   endtask : snap

   // Wake from a halt flavour and time the stabilising phase
   task automatic stab(input logic [5:0] m);
      int n;
      n = 0;
      ev <= m;
      @(posedge clk_i);
      ev <= 6'h0;
      do begin
         @(posedge clk_i);
         n++;
      end while (mode_o === psm_pkg::MODE_STAB && n < 5000);
      chk(n >= d && n <= d + 4, 1'b1);
      wt(2);
   endtask : stab

   task automatic wrap_up;
      $display("compares %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #5_000_000;
      num_errors++;
      wrap_up;
   end

   initial begin
      for (int o = 0; o < 2; o++) begin
         dly_opt <= o[0];
         rst_i <= 1'b1;
         wt(5);
         rst_i <= 1'b0;
         d = o ? 4096 : 256;
         wt(2);
         chk(mode_o, psm_pkg::MODE_RUN);
         chk({osc_on_o, rtc_run_o}, 2'b11);
         wb(1'b0, `PSM_CTRL_OFS, 32'h0);
         chk(rd, `PSM_CTRL_RESET);
         wb(1'b0, `PSM_STATUS_OFS, 32'h0);
         chk(rd, {27'h0, o[0], 4'h0});
         wb(1'b0, 4'h8, 32'h0);
         chk(rd, 32'h0);
         for (int s = 0; s < 4; s++) begin
            seed = xs(seed);
            wb(1'b1, `PSM_CTRL_OFS, {seed[31:4], 1'b0, s[1:0], 1'b1});
            wb(1'b0, `PSM_CTRL_OFS, 32'h0);
            chk(rd, {28'h0, 1'b0, s[1:0], 1'b1});
            // Settling span covers the worst-case boundary wait
            wt(40);
            snap;
            wt(64);
            chk(cpu_n - c0, exp_ticks(64, s));
            chk(per_n - p0, exp_ticks(64, s));
         end
         pulse(ev_wait);
         chk(mode_o, psm_pkg::MODE_WAIT);
         chk(mask, 2'h2);
         snap;
         wt(32);
         chk(cpu_n - c0, 0);
         chk(per_n - p0, exp_ticks(32, 3));
         pulse(ev_pend);
         chk(mode_o, psm_pkg::MODE_RUN);
         chk(srv, s0 + 8'h1);
         chk(mask, 2'h1);
         wb(1'b1, `PSM_CTRL_OFS, 32'h0);
         snap;
         pulse(ev_halt | ev_pend);
         chk(mode_o, psm_pkg::MODE_RUN);
         chk(srv, s0 + 8'h1);
         wdg_on <= 1'b1;
         wdg_opt <= 1'b0;
         pulse(ev_halt);
         chk(wdr, w0 + 8'h1);
         chk(mode_o, psm_pkg::MODE_RUN);
         wb(1'b1, `PSM_CTRL_OFS, 32'h8);
         snap;
         pulse(ev_halt);
         chk(mode_o, psm_pkg::MODE_AHALT);
         chk({osc_on_o, rtc_run_o, wdr}, {2'b11, w0});
         seed = xs(seed);
         wt(1 + seed[2:0]);
         pulse(ev_hwake);
         chk(mode_o, psm_pkg::MODE_AHALT);
         pulse(ev_rtc);
         chk(mode_o, psm_pkg::MODE_RUN);
         chk(srv, s0 + 8'h1);
         // enable kept set through the delay
         wt(d + 8);
         pulse(ev_halt);
         stab(ev_rst);
         chk(rfe, f0 + 8'h1);
         wdg_on <= 1'b0;
         wdg_opt <= 1'b1;
         wb(1'b1, `PSM_CTRL_OFS, 32'h0);
         snap;
         pulse(ev_halt);
         chk(mode_o, psm_pkg::MODE_HALT);
         chk({osc_on_o, rtc_run_o}, 2'b00);
         stab(ev_hwake);
         chk(srv, s0 + 8'h1);
         // Enable cleared inside the delay: halted until it runs out
         wb(1'b1, `PSM_CTRL_OFS, 32'h8);
         pulse(ev_halt);
         snap;
         pulse(ev_rtc);
         wb(1'b1, `PSM_CTRL_OFS, 32'h0);
         chk(mode_o, psm_pkg::MODE_STAB);
         k = 0;
         while (mode_o === psm_pkg::MODE_STAB && k < 5000) begin
            @(posedge clk_i);
            k++;
         end
         chk(k >= d - 8 && k <= d, 1'b1);
         chk({mode_o, srv}, {psm_pkg::MODE_RUN, s0 + 8'h1});
         $display("pass with delay %0d done", d);
      end
      wrap_up;
   end
endmodule : power_saving_mode_controller_tb
`default_nettype wire

// ==== src/power_mode_ctrl.sv ====
// Power saving mode sequencer with Wishbone control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"
module power_mode_ctrl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        wait_instr_i,
   input  wire logic        halt_instr_i,
   input  wire logic        irq_pending_i,
   input  wire logic        rtc_irq_i,
   input  wire logic        halt_wake_irq_i,
   input  wire logic        reset_req_i,
   input  wire logic        watchdog_active_i,
   input  wire logic        watchdog_halt_option_i,
   input  wire logic        delay_option_i,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             osc_on_o,
   output logic             rtc_run_o,
   output logic             mask_force_o,
   output logic             irq_service_o,
   output logic             reset_fetch_o,
   output logic             watchdog_reset_o,
   output logic [2:0]       mode_o
);

   typedef struct packed {
      psm_pkg::mode_e mode;
      logic           slow_mode_enable;
      logic [1:0]     slow_clock_select;
      logic           osc_irq_enable;
      logic           delay_long;
      logic           rtc_window;
      logic           wake_by_reset;
      logic           wake_by_irq;
      logic           cpu_en;
      logic           per_en;
      logic           osc_on;
      logic           rtc_run;
      logic           mask_force;
      logic           irq_service;
      logic           reset_fetch;
      logic           wdg_reset;
      logic           tmr_start;
      logic           ack;
      logic [31:0]    dat;
   } state_s;

   state_s cur;
   state_s next_cur;
   logic   guard_trip;
   logic   bus_req;

   psm_clk_if link ();

   slow_divider u_div (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .link  (link.div)
   );

   stab_timer u_tmr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .link  (link.tmr)
   );

   // Slow mode controls feed the divider
   assign link.slow_en   = cur.slow_mode_enable;
   assign link.div_sel   = cur.slow_clock_select;
   assign link.tmr_start = cur.tmr_start;
   assign link.tmr_long  = cur.delay_long;

   assign bus_req = cyc_i && stb_i && !cur.ack;

   assign guard_trip = cur.rtc_window && link.tmr_busy
                       && !cur.osc_irq_enable;

   always_comb begin
      next_cur             = cur;
      next_cur.ack         = 1'b0;
      next_cur.mask_force  = 1'b0;
      next_cur.irq_service = 1'b0;
      next_cur.reset_fetch = 1'b0;
      next_cur.wdg_reset   = 1'b0;
      next_cur.tmr_start   = 1'b0;

      // Unmapped offsets answer with zero and drop the write
      if (bus_req) begin
         next_cur.ack = 1'b1;
         next_cur.dat = 32'h0000_0000;
         if (adr_i == `PSM_CTRL_OFS) begin
            next_cur.dat[`PSM_CTRL_SLOW_BIT] = cur.slow_mode_enable;
            next_cur.dat[`PSM_CTRL_SEL_MSB:`PSM_CTRL_SEL_LSB] =
               cur.slow_clock_select;
            next_cur.dat[`PSM_CTRL_IRQEN_BIT] = cur.osc_irq_enable;
            if (we_i && sel_i[0]) begin
               next_cur.slow_mode_enable = dat_i[`PSM_CTRL_SLOW_BIT];
               next_cur.slow_clock_select =
                  dat_i[`PSM_CTRL_SEL_MSB:`PSM_CTRL_SEL_LSB];
               next_cur.osc_irq_enable = dat_i[`PSM_CTRL_IRQEN_BIT];
            end
         end else if (adr_i == `PSM_STATUS_OFS) begin
            next_cur.dat[`PSM_STAT_MODE_MSB:`PSM_STAT_MODE_LSB] = cur.mode;
            next_cur.dat[`PSM_STAT_BUSY_BIT] = link.tmr_busy;
            next_cur.dat[`PSM_STAT_LONG_BIT] = cur.delay_long;
         end
      end

      if (link.tmr_done) begin
         next_cur.rtc_window = 1'b0;
      end

      unique case (cur.mode)
         psm_pkg::MODE_RUN: begin
            if (reset_req_i) begin
               next_cur.reset_fetch = 1'b1;
            end else if (guard_trip) begin
               // Halt for the rest of the delay
               next_cur.mode          = psm_pkg::MODE_STAB;
               next_cur.rtc_window    = 1'b0;
               next_cur.wake_by_reset = 1'b0;
               next_cur.wake_by_irq   = 1'b0;
            end else if (halt_instr_i) begin
               if (irq_pending_i) begin
                  next_cur.mask_force  = 1'b1;
                  next_cur.irq_service = 1'b1;
               end else if (cur.osc_irq_enable) begin
                  next_cur.mode       = psm_pkg::MODE_AHALT;
                  next_cur.mask_force = 1'b1;
               end else if (watchdog_active_i
                            && !watchdog_halt_option_i) begin
                  next_cur.wdg_reset = 1'b1;
               end else begin
                  next_cur.mode       = psm_pkg::MODE_HALT;
                  next_cur.mask_force = 1'b1;
               end
            end else if (wait_instr_i) begin
               next_cur.mode       = psm_pkg::MODE_WAIT;
               next_cur.mask_force = 1'b1;
            end
         end
         psm_pkg::MODE_WAIT: begin
            // Only interrupt or reset ends wait
            if (reset_req_i) begin
               next_cur.mode        = psm_pkg::MODE_RUN;
               next_cur.reset_fetch = 1'b1;
            end else if (irq_pending_i) begin
               // Core stacks flags on this service pulse
               next_cur.mode        = psm_pkg::MODE_RUN;
               next_cur.irq_service = 1'b1;
            end
         end
         psm_pkg::MODE_AHALT: begin
            if (reset_req_i) begin
               next_cur.mode          = psm_pkg::MODE_STAB;
               next_cur.tmr_start     = 1'b1;
               next_cur.wake_by_reset = 1'b1;
               next_cur.wake_by_irq   = 1'b0;
            end else if (rtc_irq_i) begin
               next_cur.mode        = psm_pkg::MODE_RUN;
               next_cur.irq_service = 1'b1;
               next_cur.tmr_start   = 1'b1;
               next_cur.rtc_window  = 1'b1;
            end
         end
         psm_pkg::MODE_HALT: begin
            if (reset_req_i || halt_wake_irq_i) begin
               next_cur.mode          = psm_pkg::MODE_STAB;
               next_cur.tmr_start     = 1'b1;
               next_cur.wake_by_reset = reset_req_i;
               next_cur.wake_by_irq   = !reset_req_i;
            end
         end
         psm_pkg::MODE_STAB: begin
            if (link.tmr_done) begin
               next_cur.mode        = psm_pkg::MODE_RUN;
               next_cur.reset_fetch = cur.wake_by_reset;
               next_cur.irq_service = cur.wake_by_irq;
            end
         end
         default: begin
            next_cur.mode = psm_pkg::MODE_RUN;
         end
      endcase

      // CPU stops in wait, peripherals run
      // Both clocks follow the divider tick
      next_cur.cpu_en = link.tick && next_cur.mode == psm_pkg::MODE_RUN;
      next_cur.per_en = link.tick
                        && (next_cur.mode == psm_pkg::MODE_RUN
                            || next_cur.mode == psm_pkg::MODE_WAIT);
      next_cur.osc_on  = next_cur.mode != psm_pkg::MODE_HALT;
      next_cur.rtc_run = next_cur.mode != psm_pkg::MODE_HALT
                         && next_cur.mode != psm_pkg::MODE_STAB;
   end

   // Reset returns to run with slow mode off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur                   <= '0;
         cur.mode              <= psm_pkg::MODE_RUN;
         cur.slow_clock_select <=
            2'(`PSM_CTRL_RESET >> `PSM_CTRL_SEL_LSB);
         cur.osc_on            <= 1'b1;
         cur.rtc_run           <= 1'b1;
         cur.delay_long        <= delay_option_i;
      end else begin
         cur <= next_cur;
      end
   end

   assign dat_o            = cur.dat;
   assign ack_o            = cur.ack;
   assign cpu_clk_en_o     = cur.cpu_en;
   assign periph_clk_en_o  = cur.per_en;
   assign osc_on_o         = cur.osc_on;
   assign rtc_run_o        = cur.rtc_run;
   assign mask_force_o     = cur.mask_force;
   assign irq_service_o    = cur.irq_service;
   assign reset_fetch_o    = cur.reset_fetch;
   assign watchdog_reset_o = cur.wdg_reset;
   assign mode_o           = cur.mode;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence halt_reset_s;
      (cur.mode == psm_pkg::MODE_AHALT || cur.mode == psm_pkg::MODE_HALT)
      && reset_req_i;
   endsequence

   sequence stab_hold_s;
      (cur.mode == psm_pkg::MODE_STAB && !cur.cpu_en) [*8];
   endsequence

   wait_mask_a: assert property (
      cur.mode == psm_pkg::MODE_RUN
      && next_cur.mode == psm_pkg::MODE_WAIT |=> cur.mask_force)
      else $error("mask not forced on wait entry");

   cpu_stop_a: assert property (
      cur.mode == psm_pkg::MODE_WAIT |-> !cur.cpu_en)
      else $error("cpu clocked while not running");

   halt_select_a: assert property (
      $rose(cur.mode == psm_pkg::MODE_AHALT) |-> $past(cur.osc_irq_enable))
      else $error("active-halt entered with irq enable clear");

   rtc_fast_wake_a: assert property (
      cur.mode == psm_pkg::MODE_AHALT && rtc_irq_i && !reset_req_i
      |=> cur.mode == psm_pkg::MODE_RUN && cur.irq_service)
      else $error("counter wake delayed");

   reset_delay_a: assert property (
      halt_reset_s |=> stab_hold_s)
      else $error("reset exit skipped stabilisation");

   stab_exit_a: assert property (
      cur.mode == psm_pkg::MODE_STAB && link.tmr_done
      |=> cur.mode == psm_pkg::MODE_RUN)
      else $error("no resume after stabilisation");

   halt_osc_a: assert property (
      cur.mode == psm_pkg::MODE_HALT |-> !cur.osc_on && !cur.per_en)
      else $error("oscillator on in halt");

   ahalt_clk_a: assert property (
      cur.mode == psm_pkg::MODE_AHALT |-> cur.rtc_run && !cur.per_en)
      else $error("active-halt clocks wrong");

   wdg_halt_a: assert property (
      cur.mode == psm_pkg::MODE_RUN && halt_instr_i && !reset_req_i
      && !guard_trip && !irq_pending_i && !cur.osc_irq_enable
      && watchdog_active_i && !watchdog_halt_option_i
      |=> cur.wdg_reset && cur.mode == psm_pkg::MODE_RUN)
      else $error("halt not refused by watchdog option");

   delay_hold_a: assert property (
      !$past(rst_i) |-> $stable(cur.delay_long))
      else $error("delay option changed in operation");

   guard_halt_a: assert property (
      cur.mode == psm_pkg::MODE_RUN && guard_trip && !reset_req_i
      |=> cur.mode == psm_pkg::MODE_STAB && !cur.irq_service)
      else $error("early enable clear not halted");

   pending_wake_a: assert property (
      cur.mode == psm_pkg::MODE_RUN && halt_instr_i && irq_pending_i
      && !reset_req_i && !guard_trip
      |=> cur.mask_force && cur.irq_service
          && cur.mode == psm_pkg::MODE_RUN)
      else $error("pending irq did not wake at once");

   // Two cycles of history: the first tick after enabling is still full rate
   slow_rate_a: assert property (
      cur.slow_mode_enable && cur.slow_clock_select == 2'h0
      && $past(cur.slow_mode_enable, 2) && cur.cpu_en |=> !cur.cpu_en)
      else $error("slow clock not divided");

   halt_mask_a: assert property (
      cur.mode == psm_pkg::MODE_RUN
      && (next_cur.mode == psm_pkg::MODE_AHALT
          || next_cur.mode == psm_pkg::MODE_HALT) |=> cur.mask_force)
      else $error("mask not forced on halt entry");

   wait_hold_a: assert property (
      cur.mode == psm_pkg::MODE_WAIT && !irq_pending_i && !reset_req_i
      |=> cur.mode == psm_pkg::MODE_WAIT)
      else $error("wait left without interrupt or reset");

   ahalt_hold_a: assert property (
      cur.mode == psm_pkg::MODE_AHALT && !rtc_irq_i && !reset_req_i
      |=> cur.mode == psm_pkg::MODE_AHALT)
      else $error("active-halt left by a foreign wake");

   bus_ack_a: assert property (
      bus_req |=> ack_o ##1 !ack_o)
      else $error("bus ack not a single cycle");

endmodule : power_mode_ctrl
`default_nettype wire

// ==== src/psm_clk_if.sv ====
// Link between the mode sequencer, its clock divider and its delay timer
`timescale 1ns/1ps
`default_nettype none
interface psm_clk_if;
   logic       slow_en;
   logic [1:0] div_sel;
   logic       tick;
   logic       tmr_start;
   logic       tmr_long;
   logic       tmr_busy;
   logic       tmr_done;

   modport ctrl (output slow_en, div_sel, tmr_start, tmr_long,
                 input  tick, tmr_busy, tmr_done);
   modport div  (input  slow_en, div_sel, output tick);
   modport tmr  (input  tmr_start, tmr_long, output tmr_busy, tmr_done);
endinterface : psm_clk_if
`default_nettype wire

// ==== src/psm_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

`define PSM_CTRL_OFS       4'h0
`define PSM_STATUS_OFS     4'h4

`define PSM_CTRL_SLOW_BIT  0
`define PSM_CTRL_SEL_LSB   1
`define PSM_CTRL_SEL_MSB   2
`define PSM_CTRL_IRQEN_BIT 3

`define PSM_STAT_MODE_LSB  0
`define PSM_STAT_MODE_MSB  2
`define PSM_STAT_BUSY_BIT  3
`define PSM_STAT_LONG_BIT  4

`define PSM_CTRL_RESET     4'h0
`define PSM_MASK_ALL_ON    2'h2

`define PSM_DELAY_SHORT    13'h0100
`define PSM_DELAY_LONG     13'h1000

`endif

// ==== src/psm_pkg.sv ====
// Types shared by the power saving mode controller
package psm_pkg;

   typedef enum logic [2:0] {
      MODE_RUN   = 3'b000,
      MODE_WAIT  = 3'b001,
      MODE_AHALT = 3'b010,
      MODE_HALT  = 3'b011,
      MODE_STAB  = 3'b100
   } mode_e;

   typedef struct packed {
      logic [3:0] count;
      logic [3:0] limit;
      logic       tick;
   } div_s;

   typedef struct packed {
      logic [12:0] count;
      logic        busy;
      logic        long_sel;
      logic        done;
   } tmr_s;

   // Reload value of the slow divider: period minus one
   function automatic logic [3:0] div_limit(input logic slow_en,
                                            input logic [1:0] sel);
      logic [4:0] period;
      period = 5'h02 << sel;
      div_limit = slow_en ? 4'(period - 5'h01) : 4'h0;
   endfunction : div_limit

endpackage : psm_pkg

// ==== src/slow_divider.sv ====
// Slow mode clock divider producing one-cycle CPU clock ticks
`timescale 1ns/1ps
`default_nettype none
module slow_divider (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   psm_clk_if.div      link
);
   psm_pkg::div_s cur;
   psm_pkg::div_s next_cur;

   always_comb begin
      next_cur      = cur;
      next_cur.tick = 1'b0;
      if (cur.count == 4'h0) begin
         next_cur.tick  = 1'b1;
         next_cur.limit = psm_pkg::div_limit(link.slow_en, link.div_sel);
         next_cur.count = next_cur.limit;
      end else begin
         next_cur.count = cur.count - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.tick = cur.tick;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   no_runt_a: assert property (
      cur.tick && cur.limit != 4'h0 |=> !cur.tick)
      else $error("divider tick shorter than its period");
   tick_period_a: assert property (
      cur.tick && cur.limit == 4'h1 |=> !cur.tick ##1 cur.tick)
      else $error("divide by two tick spacing wrong");
endmodule : slow_divider
`default_nettype wire

// ==== src/stab_timer.sv ====
// Oscillator stabilisation delay counter, 256 or 4096 cycles
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.svh"
module stab_timer (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   psm_clk_if.tmr      link
);
   psm_pkg::tmr_s cur;
   psm_pkg::tmr_s next_cur;

   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      if (link.tmr_start) begin
         next_cur.busy     = 1'b1;
         next_cur.long_sel = link.tmr_long;
         next_cur.count    = link.tmr_long ? `PSM_DELAY_LONG - 13'h1
                                           : `PSM_DELAY_SHORT - 13'h1;
      end else if (cur.busy) begin
         if (cur.count == 13'h0) begin
            next_cur.busy = 1'b0;
            next_cur.done = 1'b1;
         end else begin
            next_cur.count = cur.count - 13'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.tmr_busy = cur.busy;
   assign link.tmr_done = cur.done;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A restart while busy is legal, so load and step are checked apart
   short_delay_a: assert property (
      link.tmr_start && !link.tmr_long
      |=> cur.busy && cur.count == `PSM_DELAY_SHORT - 13'h1)
      else $error("short stabilisation delay not 256 cycles");
   delay_step_a: assert property (
      cur.busy && !link.tmr_start
      |=> (($past(cur.count) == 13'h0) ? (cur.done && !cur.busy)
           : (cur.busy && cur.count == $past(cur.count) - 13'h1)))
      else $error("stabilisation count not one per cycle");
endmodule : stab_timer
`default_nettype wire
